// file: bench/spp_assertions.sv
// wire checker for the serial programming port pins
// assumes instantiation beside the interface joining host and device
`timescale 1ns/1ps
module spp_assertions (
    input wire logic mclk,
    input wire logic srst,
    input wire logic prog_clock_pin,
    input wire logic master_clear_pin,
    input wire logic data_host_o,
    input wire logic data_host_oe,
    input wire logic data_dev_o,
    input wire logic data_dev_oe,
    input wire logic prog_data_pin
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic clk_q;
    logic [4:0] rise_cnt_q;
    // link clock rises seen while the device drives data
    always_ff @(posedge mclk) begin
        clk_q <= prog_clock_pin;
    end
    always_ff @(posedge mclk) begin
        if (srst || !data_dev_oe) begin
            rise_cnt_q <= 5'h0;
        end else if (prog_clock_pin && !clk_q) begin
            rise_cnt_q <= rise_cnt_q + 5'h1;
        end
    end
    sequence s_high_phase;
        prog_clock_pin [*4] ##1 !prog_clock_pin;
    endsequence
    sequence s_low_phase;
        !prog_clock_pin [*4];
    endsequence
    a_link_high_time: assert property ($rose(prog_clock_pin) |-> s_high_phase)
        else $error("link clock high phase not four cycles");
    a_link_low_time: assert property ($fell(prog_clock_pin) |-> s_low_phase)
        else $error("link clock low phase under four cycles");
    a_host_data_steady: assert property (data_host_oe && prog_clock_pin && clk_q
        |-> $stable(data_host_o)) else $error("host data moved while clock high");
    a_dev_data_steady: assert property (data_dev_oe && prog_clock_pin && clk_q
        |-> $stable(data_dev_o)) else $error("device data moved while clock high");
    a_no_contention: assert property (!(data_dev_oe && data_host_oe))
        else $error("both ends drive the data pin");
    a_release_on_rise: assert property ($fell(data_dev_oe)
        |-> !master_clear_pin || prog_clock_pin || clk_q)
        else $error("device released data away from a rise");
    a_read_rise_count: assert property ($fell(data_dev_oe) && master_clear_pin
        |-> rise_cnt_q == 5'h11) else $error("device drove data for wrong clock count");
    a_clear_stops_drive: assert property ($fell(master_clear_pin)
        |-> ##[0:3] !data_dev_oe) else $error("device still drives after clear");
    c_read_done: cover property ($fell(data_dev_oe));
endmodule : spp_assertions

// file: bench/spp_bench.sv
// self-checking bench: host and device joined, plus a bench-driven second device
// assumes design files compiled first with spp_regs.svh on the include path
`timescale 1ns/1ps
`include "spp_regs.svh"
module spp_bench;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic enter_req, exec_req, read_req, exec_ready, busy, entered, read_valid;
    logic prog_mode, exec_valid, cpu_clk_pulse, prog_mode_b, exec_valid_b;
    logic [23:0] exec_word, instruction_reg, instruction_reg_b;
    logic [15:0] vis, read_data;
    logic [15:0] rd_seen = 'x;
    logic [31:0] acc;
    logic bits[$];
    int num_errors = 0;
    int n_checks = 0;
    int pulses = 0;
    spp_if i_if();
    spp_if i_if2();
    spp_host i_spp_host (.mclk(mclk), .srst(srst), .pins(i_if), .enter_req(enter_req),
        .exec_req(exec_req), .exec_word(exec_word), .read_req(read_req), .busy(busy),
        .entered(entered), .read_data(read_data), .read_valid(read_valid));
    spp_device i_spp_device (.mclk(mclk), .srst(srst), .pins(i_if), .visible_output_reg(vis),
        .prog_mode(prog_mode), .instruction_reg(instruction_reg), .exec_valid(exec_valid),
        .exec_ready(exec_ready), .cpu_clk_pulse(cpu_clk_pulse));
    spp_device i_spp_device_2 (.mclk(mclk), .srst(srst), .pins(i_if2),
        .visible_output_reg(16'h0), .prog_mode(prog_mode_b),
        .instruction_reg(instruction_reg_b), .exec_valid(exec_valid_b),
        .exec_ready(1'b0), .cpu_clk_pulse());
    spp_assertions i_spp_assertions (.mclk(mclk), .srst(srst),
        .prog_clock_pin(i_if.prog_clock_pin), .master_clear_pin(i_if.master_clear_pin),
        .data_host_o(i_if.data_host_o), .data_host_oe(i_if.data_host_oe),
        .data_dev_o(i_if.data_dev_o), .data_dev_oe(i_if.data_dev_oe),
        .prog_data_pin(i_if.prog_data_pin));
    always #25 mclk = ~mclk;
    // wire bits as latched on each link rise
    always @(posedge i_if.prog_clock_pin) bits.push_back(i_if.prog_data_pin);
    always @(posedge mclk) begin
        if (cpu_clk_pulse === 1'b1) pulses++;
        if (read_valid === 1'b1) rd_seen = read_data;
    end
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task complete_run;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    // one host request: 0 enter, 1 execute, 2 read
    task automatic op(input int k, input logic [23:0] w);
        int n = 0;
        @(posedge mclk);
        enter_req <= (k == 0);
        exec_req <= (k == 1);
        read_req <= (k == 2);
        exec_word <= w;
        @(posedge mclk);
        enter_req <= 1'b0;
        exec_req <= 1'b0;
        read_req <= 1'b0;
        repeat (2) @(posedge mclk);
        while (busy === 1'b1 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        check("busy end", n < 3000, 1);
        repeat (8) @(posedge mclk);
    endtask : op
    task automatic gather(input int n, input int base);
        acc = 32'h0;
        for (int i = 0; i < n; i++) acc[i] = bits[base + i];
    endtask : gather
    // bench as programmer on the second link
    task automatic bb(input logic b);
        // data moves with the fall; 8 mclk per link period
        i_if2.data_host_o <= b;
        repeat (4) @(posedge mclk);
        i_if2.prog_clock_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        i_if2.prog_clock_pin <= 1'b0;
    endtask : bb
    task automatic bb_word(input logic [31:0] v, input int n, input bit msb);
        for (int i = 0; i < n; i++) bb(msb ? v[n - 1 - i] : v[i]);
    endtask : bb_word
    task automatic bb_enter(input logic [31:0] key);
        @(posedge mclk);
        i_if2.master_clear_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        i_if2.master_clear_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        bb_word(key, 32, 1'b1);
        @(posedge mclk);
        i_if2.master_clear_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        bb_word(32'h0, 5, 1'b0);
        repeat (8) @(posedge mclk);
    endtask : bb_enter
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        complete_run;
    end
    initial begin
        {enter_req, exec_req, read_req, exec_ready} = 4'h0;
        exec_word = 24'h0;
        vis = 16'hc3a5;
        i_if2.prog_clock_pin = 1'b0;
        i_if2.master_clear_pin = 1'b0;
        i_if2.data_host_o = 1'b0;
        i_if2.data_host_oe = 1'b1;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        op(1, 24'h123456);
        check("clocks before entry", bits.size(), 0);
        op(0, 24'h0);
        for (int i = 0; i < 32; i++) acc = {acc[30:0], bits[i]};
        check("key on wire", acc, `SPP_ENTRY_KEY);
        check("entered", {entered, prog_mode}, 2'b11);
        bits.delete();
        pulses = 0;
        op(1, 24'h5a0f3c);
        gather(28, 0);
        check("exec on wire", acc, {4'h0, 24'h5a0f3c, 4'h0});
        check("cpu clocks", pulses, 28);
        op(1, 24'h81e7a2);
        bits.delete();
        op(2, 24'h0);
        gather(28, 0);
        check("read on wire", {acc[27:12], acc[3:0]}, {vis, 4'h1});
        check("read data", rd_seen, vis);
        check("buffer head", {exec_valid, instruction_reg}, {1'b1, 24'h5a0f3c});
        @(posedge mclk);
        exec_ready <= 1'b1;
        @(posedge mclk);
        exec_ready <= 1'b0;
        @(posedge mclk);
        check("buffer second", {exec_valid, instruction_reg}, {1'b1, 24'h81e7a2});
        @(posedge mclk);
        exec_ready <= 1'b1;
        @(posedge mclk);
        exec_ready <= 1'b0;
        @(posedge mclk);
        check("buffer empty", exec_valid, 1'b0);
        bb_enter(`SPP_ENTRY_KEY ^ 32'h1);
        check("bad key", prog_mode_b, 1'b0);
        bb_enter(`SPP_ENTRY_KEY);
        check("good key", prog_mode_b, 1'b1);
        bb_word(32'h5, 4, 1'b0);
        bb_word(32'h0, 4, 1'b0);
        bb_word(32'h00a3c5, 24, 1'b0);
        bb_word(32'h0, 4, 1'b0);
        repeat (8) @(posedge mclk);
        check("after reserved", {exec_valid_b, instruction_reg_b}, {1'b1, 24'h00a3c5});
        complete_run;
    end
endmodule : spp_bench

// file: design/spp_device.sv
// device end: key check, control code decode, instruction shift-in, output shift-out
// assumes pins asynchronous to mclk; link clock far slower than mclk
`timescale 1ns/1ps
`include "spp_regs.svh"
module spp_device (
    input wire logic mclk,
    input wire logic srst,
    spp_if.device pins,
    input wire logic [15:0] visible_output_reg,
    output logic prog_mode,
    output logic [23:0] instruction_reg,
    output logic exec_valid,
    input wire logic exec_ready,
    output logic cpu_clk_pulse
);
    import spp_pkg::*;
    logic [1:0] clk_s_q, master_clear_pin_s_q, dat_s_q;
    logic clk_last_q;
    spp_state_t state_q;
    logic [31:0] key_q;
    logic [5:0] cnt_q;
    logic [23:0] sh_q;
    logic [15:0] out_q;
    logic [2:0] post_q;
    logic [4:0] exe_q;
    logic dout_q, doe_q;
    logic [23:0] buf_d0_q, buf_d1_q;
    logic buf_v0_q, buf_v1_q;
    logic rise, fall, clk_s, master_clear_pin_s, dat_s, push;

    always_ff @(posedge mclk) begin
        clk_s_q <= {clk_s_q[0], pins.prog_clock_pin};
        master_clear_pin_s_q <= {master_clear_pin_s_q[0], pins.master_clear_pin};
        dat_s_q <= {dat_s_q[0], pins.prog_data_pin};
        clk_last_q <= clk_s_q[1];
    end
    assign clk_s = clk_s_q[1];
    assign master_clear_pin_s = master_clear_pin_s_q[1];
    assign dat_s = dat_s_q[1];
    assign rise = clk_s & ~clk_last_q;
    assign fall = ~clk_s & clk_last_q;
    assign push = rise && state_q == SPP_INSN && cnt_q == 6'(`SPP_INSN_BITS - 5'd1);

    // main sequencer
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= SPP_OFF;
            key_q <= 32'h0;
            cnt_q <= 6'h0;
            sh_q <= 24'h0;
            post_q <= 3'h0;
        end else if (state_q != SPP_OFF && state_q != SPP_KEY && state_q != SPP_WAIT_HI
                     && !master_clear_pin_s) begin
            state_q <= SPP_KEY;
            key_q <= 32'h0;
            cnt_q <= 6'h0;
        end else begin
            unique case (state_q)
                SPP_OFF: begin
                    if (!master_clear_pin_s) begin
                        state_q <= SPP_KEY;
                        key_q <= 32'h0;
                        cnt_q <= 6'h0;
                    end
                end
                SPP_KEY: begin
                    if (master_clear_pin_s) begin
                        state_q <= (key_q == `SPP_ENTRY_KEY && cnt_q == `SPP_KEY_BITS) ?
                            SPP_WAIT_HI : SPP_OFF;
                        post_q <= 3'h0;
                    end else if (rise && cnt_q != `SPP_KEY_BITS) begin
                        key_q <= {key_q[30:0], dat_s};
                        cnt_q <= cnt_q + 6'h1;
                    end
                end
                SPP_WAIT_HI: begin
                    if (rise) begin
                        post_q <= post_q + 3'h1;
                        if (post_q == `SPP_POST_CLKS - 3'd1) begin
                            state_q <= SPP_CODE;
                            cnt_q <= 6'h0;
                        end
                    end
                end
                SPP_CODE: begin
                    if (rise) begin
                        sh_q <= {dat_s, sh_q[23:1]};
                        cnt_q <= cnt_q + 6'h1;
                        if (cnt_q == 6'(`SPP_CODE_BITS - 3'd1)) begin
                            cnt_q <= 6'h0;
                            unique case ({dat_s, sh_q[23:21]})
                                `SPP_CODE_EXEC: state_q <= SPP_INSN;
                                `SPP_CODE_READ: state_q <= SPP_IDLE;
                                default: state_q <= SPP_CODE;
                            endcase
                        end
                    end
                end
                SPP_INSN: begin
                    if (rise) begin
                        sh_q <= {dat_s, sh_q[23:1]};
                        cnt_q <= cnt_q + 6'h1;
                        if (push) begin
                            state_q <= SPP_CODE;
                            cnt_q <= 6'h0;
                        end
                    end
                end
                SPP_IDLE: begin
                    if (rise) begin
                        cnt_q <= cnt_q + 6'h1;
                        if (cnt_q == 6'(`SPP_IDLE_CLKS - 5'd1)) begin
                            state_q <= SPP_OUT;
                            cnt_q <= 6'h0;
                        end
                    end
                end
                SPP_OUT: begin
                    if (rise) begin
                        cnt_q <= cnt_q + 6'h1;
                        if (cnt_q == 6'(`SPP_VISIBLE_OUTPUT_REG_BITS - 5'd1)) begin
                            state_q <= SPP_CODE;
                            cnt_q <= 6'h0;
                        end
                    end
                end
            endcase
        end
    end

    // read-out driver: load during SPP_IDLE, shift on falls, hold until next rise
    always_ff @(posedge mclk) begin
        if (srst) begin
            out_q <= 16'h0;
            dout_q <= 1'b0;
            doe_q <= 1'b0;
        end else if (doe_q && !master_clear_pin_s) begin
            // clear low drops the drive in any state
            doe_q <= 1'b0;
        end else if (state_q == SPP_IDLE) begin
            out_q <= visible_output_reg;
        end else if (state_q == SPP_OUT && fall) begin
            doe_q <= 1'b1;
            dout_q <= out_q[0];
            out_q <= {1'b0, out_q[15:1]};
        end else if (state_q != SPP_OUT && doe_q && rise) begin
            doe_q <= 1'b0;
        end
    end

    // two-entry buffer between shifter and cpu
    always_ff @(posedge mclk) begin
        if (srst) begin
            buf_v0_q <= 1'b0;
            buf_v1_q <= 1'b0;
            buf_d0_q <= 24'h0;
            buf_d1_q <= 24'h0;
        end else begin
            if (buf_v0_q && exec_ready) begin
                buf_v0_q <= buf_v1_q | push;
                buf_d0_q <= buf_v1_q ? buf_d1_q : {dat_s, sh_q[23:1]};
                buf_v1_q <= buf_v1_q & push;
                if (buf_v1_q && push) buf_d1_q <= {dat_s, sh_q[23:1]};
            end else if (push) begin
                if (!buf_v0_q) begin
                    buf_v0_q <= 1'b1;
                    buf_d0_q <= {dat_s, sh_q[23:1]};
                end else if (!buf_v1_q) begin
                    buf_v1_q <= 1'b1;
                    buf_d1_q <= {dat_s, sh_q[23:1]};
                end
            end
        end
    end

    // execute window of four clocks and clock forwarding
    always_ff @(posedge mclk) begin
        if (srst) begin
            exe_q <= 5'h0;
            cpu_clk_pulse <= 1'b0;
            prog_mode <= 1'b0;
        end else begin
            cpu_clk_pulse <= rise && state_q != SPP_OFF && state_q != SPP_KEY;
            prog_mode <= state_q != SPP_OFF && state_q != SPP_KEY && state_q != SPP_WAIT_HI;
            if (push) exe_q <= `SPP_EXEC_CLKS;
            else if (rise && exe_q != 5'h0) exe_q <= exe_q - 5'h1;
        end
    end

    assign instruction_reg = buf_d0_q;
    assign exec_valid = buf_v0_q;
    assign pins.data_dev_o = dout_q;
    assign pins.data_dev_oe = doe_q;
endmodule : spp_device

// file: design/spp_host.sv
// programmer end: clear pulse, key, entry pulses, then code and data transfers
// assumes user issues one request at a time; mclk at 20 MHz
`timescale 1ns/1ps
`include "spp_regs.svh"
module spp_host (
    input wire logic mclk,
    input wire logic srst,
    spp_if.host pins,
    input wire logic enter_req,
    input wire logic exec_req,
    input wire logic [23:0] exec_word,
    input wire logic read_req,
    output logic busy,
    output logic entered,
    output logic [15:0] read_data,
    output logic read_valid
);
    import spp_pkg::*;
    spp_host_state_t state_q;
    logic [2:0] div_q;
    logic clk_q, master_clear_pin_q, dout_q, doe_q, rd_q;
    logic [5:0] cnt_q;
    logic [31:0] sh_q;
    logic [1:0] din_s_q;
    logic tick;
    assign tick = div_q == `SPP_CLK_HALF - 3'd1;

    always_ff @(posedge mclk) begin
        din_s_q <= {din_s_q[0], pins.prog_data_pin};
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= SPH_IDLE;
            div_q <= 3'h0;
            clk_q <= 1'b0;
            master_clear_pin_q <= 1'b0;
            dout_q <= 1'b0;
            doe_q <= 1'b0;
            cnt_q <= 6'h0;
            sh_q <= 32'h0;
            rd_q <= 1'b0;
            busy <= 1'b0;
            entered <= 1'b0;
            read_data <= 16'h0;
            read_valid <= 1'b0;
        end else begin
            read_valid <= 1'b0;
            div_q <= tick ? 3'h0 : div_q + 3'h1;
            unique case (state_q)
                SPH_IDLE: begin
                    busy <= 1'b0;
                    if (enter_req) begin
                        state_q <= SPH_CLEAR;
                        sh_q <= `SPP_ENTRY_KEY;
                        master_clear_pin_q <= 1'b1;
                        busy <= 1'b1;
                        entered <= 1'b0;
                    end else if (entered && (exec_req || read_req)) begin
                        state_q <= SPH_CODE;
                        sh_q <= {8'h0, exec_word};
                        rd_q <= read_req && !exec_req;
                        dout_q <= read_req && !exec_req;
                        doe_q <= 1'b1;
                        cnt_q <= 6'h0;
                        busy <= 1'b1;
                    end
                end
                SPH_CLEAR: begin
                    if (tick) begin
                        master_clear_pin_q <= 1'b0;
                        state_q <= SPH_KEY;
                        sh_q <= `SPP_ENTRY_KEY;
                        cnt_q <= 6'h0;
                        doe_q <= 1'b1;
                        // first key bit set while the clock is low
                        dout_q <= sh_q[31];
                    end
                end
                SPH_KEY: begin
                    if (tick) begin
                        clk_q <= ~clk_q;
                        if (clk_q) begin
                            sh_q <= {sh_q[30:0], 1'b0};
                            dout_q <= sh_q[30];
                            cnt_q <= cnt_q + 6'h1;
                            if (cnt_q == `SPP_KEY_BITS - 6'd1) begin
                                state_q <= SPH_ENTRY;
                                master_clear_pin_q <= 1'b1;
                                doe_q <= 1'b0;
                                cnt_q <= 6'h0;
                            end
                        end else begin
                            dout_q <= sh_q[31];
                        end
                    end
                end
                SPH_ENTRY: begin
                    if (tick) begin
                        clk_q <= ~clk_q;
                        if (clk_q) begin
                            cnt_q <= cnt_q + 6'h1;
                            if (cnt_q == 6'(`SPP_POST_CLKS - 3'd1)) begin
                                state_q <= SPH_IDLE;
                                entered <= 1'b1;
                            end
                        end
                    end
                end
                SPH_CODE, SPH_DATA, SPH_READ: begin
                    if (tick) begin
                        clk_q <= ~clk_q;
                        if (clk_q) begin
                            cnt_q <= cnt_q + 6'h1;
                            if (state_q == SPH_CODE) begin
                                dout_q <= 1'b0;
                                if (cnt_q == 6'(`SPP_CODE_BITS - 3'd1)) begin
                                    cnt_q <= 6'h0;
                                    state_q <= rd_q ? SPH_READ : SPH_DATA;
                                    doe_q <= !rd_q;
                                    dout_q <= sh_q[0];
                                end
                            end else if (state_q == SPH_DATA) begin
                                sh_q <= {1'b0, sh_q[31:1]};
                                dout_q <= sh_q[1];
                                if (cnt_q == 6'(`SPP_INSN_BITS - 5'd1)) begin
                                    state_q <= SPH_IDLE;
                                    doe_q <= 1'b0;
                                end
                            end else if (cnt_q == 6'(`SPP_IDLE_CLKS + `SPP_VISIBLE_OUTPUT_REG_BITS - 5'd1)) begin
                                state_q <= SPH_IDLE;
                                read_data <= {din_s_q[1], read_data[15:1]};
                                read_valid <= 1'b1;
                            end
                        end else if (state_q == SPH_READ && cnt_q >= 6'(`SPP_IDLE_CLKS)) begin
                            read_data <= {din_s_q[1], read_data[15:1]};
                        end
                    end
                end
                default: state_q <= SPH_IDLE;
            endcase
        end
    end

    assign pins.prog_clock_pin = clk_q;
    assign pins.master_clear_pin = master_clear_pin_q;
    assign pins.data_host_o = dout_q;
    assign pins.data_host_oe = doe_q;
endmodule : spp_host

// file: design/spp_if.sv
// pin bundle between programmer and device; resolves the data pin from enables
// assumes both ends on the same bench
`timescale 1ns/1ps
interface spp_if;
    logic prog_clock_pin;
    logic master_clear_pin;
    logic data_host_o;
    logic data_host_oe;
    logic data_dev_o;
    logic data_dev_oe;
    logic prog_data_pin;
    assign prog_data_pin = data_dev_oe ? data_dev_o : (data_host_oe ? data_host_o : 1'b1);
    modport host (output prog_clock_pin, output master_clear_pin, output data_host_o,
        output data_host_oe, input prog_data_pin);
    modport device (input prog_clock_pin, input master_clear_pin, output data_dev_o,
        output data_dev_oe, input prog_data_pin);
endinterface : spp_if

// file: design/spp_pkg.sv
// types shared by both ends of the serial programming port
// assumes spp_regs.svh on the include path
`include "spp_regs.svh"
package spp_pkg;
    typedef enum logic [2:0] {
        SPP_OFF, SPP_KEY, SPP_WAIT_HI, SPP_CODE, SPP_INSN, SPP_IDLE, SPP_OUT
    } spp_state_t;
    typedef enum logic [2:0] {
        SPH_IDLE, SPH_CLEAR, SPH_KEY, SPH_ENTRY, SPH_CODE, SPH_DATA, SPH_READ
    } spp_host_state_t;
endpackage : spp_pkg

// file: design/spp_regs.svh
// constants of the serial programming port
// assumes inclusion by bare name from package and modules
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH
`define SPP_ENTRY_KEY 32'h4d434851
`define SPP_KEY_BITS 6'd32
`define SPP_CODE_BITS 3'd4
`define SPP_INSN_BITS 5'd24
`define SPP_IDLE_CLKS 5'd8
`define SPP_VISIBLE_OUTPUT_REG_BITS 5'd16
`define SPP_EXEC_CLKS 5'd4
`define SPP_POST_CLKS 3'd5
`define SPP_CODE_EXEC 4'h0
`define SPP_CODE_READ 4'h1
// programmer clock: half period in mclk cycles (20 MHz / 8 = 2.5 MHz, under 5 MHz)
`define SPP_CLK_HALF 3'd4
`endif
